/* File: core/scfg_config_top.sv */
// APB register file for synth ratio, loop selection, enables, lock criterion and centre trim
// Summary of operation
// - synth frequency is base frequency times multiplier times 8 times numerator/denominator.
// - synth3 ratio word: numerator in bits 31:16, denominator in 15:0.
// - each synth follows the loop in its 2-bit field; codes 10, 11 reserved.
// - synth n output is enabled only while enable bit n is set.
// - per-loop 2-bit code picks phase error threshold and qualifying duration.
// - loop0 criterion at bits 1:0, loop1 at 3:2, governs reported lock state.
// - 32-bit two's-complement trim in 2^-32 steps applies to all four synths.
// - as an oscillator, output equals initial frequency times one plus trim/2^32.
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ns
`include "scfg_defines.svh"
module scfg_config_top #(
	parameter int ADDR_W = 12,
	parameter int ERR_W = 16,
	parameter logic [31:0] LOCK_SHORT_CYC = 32'(`SCFG_DUR_SHORT_CYC),
	parameter logic [31:0] LOCK_LONG_CYC = 32'(`SCFG_DUR_LONG_CYC)
) (
	input logic pclk, // block clock, 100 MHz
	input logic presetn, // async reset, active low
	input logic psel, // APB select
	input logic penable, // APB access phase
	input logic pwrite, // APB direction, high for write
	input logic [ADDR_W-1:0] paddr, // APB byte address
	input logic [31:0] pwdata, // APB write data
	input logic [3:0] pstrb, // APB byte strobes
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error on unmapped address
	input logic [ERR_W-1:0] loop0_phase_err_ns, // loop0 phase error magnitude
	input logic [ERR_W-1:0] loop1_phase_err_ns, // loop1 phase error magnitude
	output logic [15:0] synth3_numerator_field, // synth3 ratio numerator
	output logic [15:0] synth3_denominator_field, // synth3 ratio denominator
	output logic [31:0] centre_trim, // signed centre frequency offset
	output logic [3:0] synth_loop_select, // per synth: 0 first loop, 1 second
	output logic [3:0] synth_out_en, // per synth output enable
	output logic [1:0] loop0_lock_criterion, // loop0 lock criterion code
	output logic [1:0] loop1_lock_criterion, // loop1 lock criterion code
	output logic [1:0] loop_lock_fail // per loop: high while not locked
);
	scfg_pkg::scfg_top_t s_q;
	scfg_pkg::scfg_top_t s_d;
	scfg_word_if ratio_w ();
	scfg_word_if trim_w ();

	logic [7:0] idx;
	logic addr_ok;
	logic hit;
	logic setup;
	logic access;
	logic wr_en;
	logic [1:0] locked;
	logic [31:0] rdata;
	logic [15:0] wd_hi;
	logic [15:0] wd_lo;

	// decode: index is the word address, upper bits must be clear
	assign idx = paddr[9:2];
	assign addr_ok = (paddr[ADDR_W-1:10] == '0);
	assign setup = psel & ~penable & ~s_q.pready;
	assign access = psel & penable & s_q.pready;
	assign wr_en = access & pwrite & hit;
	assign wd_hi = pwdata[31:16];
	assign wd_lo = pwdata[15:0];

	always_comb begin
		case (idx)
			`SCFG_IDX_RATIO3,
			`SCFG_IDX_LOOP_SEL,
			`SCFG_IDX_OUT_EN,
			`SCFG_IDX_LOCK_CRIT,
			`SCFG_IDX_TRIM,
			`SCFG_IDX_LOCK_STAT: hit = addr_ok;
			default: hit = 1'b0;
		endcase
	end

	always_comb begin
		case (idx)
			`SCFG_IDX_RATIO3: rdata = ratio_w.live;
			`SCFG_IDX_LOOP_SEL: rdata = {24'h000000, s_q.loop_sel};
			`SCFG_IDX_OUT_EN: rdata = {24'h000000, s_q.out_en};
			`SCFG_IDX_LOCK_CRIT: rdata = {24'h000000, s_q.lock_crit};
			`SCFG_IDX_TRIM: rdata = trim_w.live;
			`SCFG_IDX_LOCK_STAT: rdata = {30'h00000000, s_q.lock_fail};
			default: rdata = 32'h00000000;
		endcase
		if (!addr_ok) begin
			rdata = 32'h00000000;
		end
	end

	// wide registers go through staging so writes take effect only once all four bytes have been written
	assign ratio_w.wr = wr_en & (idx == `SCFG_IDX_RATIO3);
	assign ratio_w.strb = pstrb;
	assign ratio_w.wdata = pwdata;
	assign trim_w.wr = wr_en & (idx == `SCFG_IDX_TRIM);
	assign trim_w.strb = pstrb;
	assign trim_w.wdata = pwdata;

	scfg_shadow_word #(
		.RESET_VAL(`SCFG_RST_RATIO3)
	) u_ratio (
		.pclk(pclk),
		.presetn(presetn),
		.w(ratio_w)
	);

	scfg_shadow_word #(
		.RESET_VAL(`SCFG_RST_TRIM)
	) u_trim (
		.pclk(pclk),
		.presetn(presetn),
		.w(trim_w)
	);

	scfg_lock_timer #(
		.ERR_W(ERR_W),
		.SHORT_CYC(LOCK_SHORT_CYC),
		.LONG_CYC(LOCK_LONG_CYC)
	) u_lock0 (
		.pclk(pclk),
		.presetn(presetn),
		.crit(s_q.lock_crit[1:0]),
		.phase_err_ns(loop0_phase_err_ns),
		.locked(locked[0])
	);

	scfg_lock_timer #(
		.ERR_W(ERR_W),
		.SHORT_CYC(LOCK_SHORT_CYC),
		.LONG_CYC(LOCK_LONG_CYC)
	) u_lock1 (
		.pclk(pclk),
		.presetn(presetn),
		.crit(s_q.lock_crit[3:2]),
		.phase_err_ns(loop1_phase_err_ns),
		.locked(locked[1])
	);

	always_comb begin
		s_d = s_q;
		s_d.pready = 1'b0;
		s_d.pslverr = 1'b0;
		// answer in the first access cycle; data and error prepared in setup
		if (setup) begin
			s_d.pready = 1'b1;
			s_d.pslverr = ~hit;
			s_d.prdata = pwrite ? 32'h00000000 : rdata;
		end
		if (wr_en && pstrb[0]) begin
			case (idx)
				`SCFG_IDX_LOOP_SEL: s_d.loop_sel = pwdata[7:0];
				`SCFG_IDX_OUT_EN: s_d.out_en = pwdata[7:0];
				`SCFG_IDX_LOCK_CRIT: s_d.lock_crit = pwdata[7:0];
				default: s_d.lock_crit = s_q.lock_crit;
			endcase
		end
		// reserved codes keep the previous loop choice
		for (int i = 0; i < `SCFG_NUM_SYNTH; i++) begin
			if (!s_q.loop_sel[2*i+1]) begin
				s_d.synth_sel[i] = s_q.loop_sel[2*i];
			end
		end
		s_d.synth_en = s_q.out_en[3:0];
		s_d.lock_fail = ~locked;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '{
				loop_sel: `SCFG_RST_LOOP_SEL,
				out_en: `SCFG_RST_OUT_EN,
				lock_crit: `SCFG_RST_LOCK_CRIT,
				lock_fail: 2'b11,
				default: '0
			};
		end else begin
			s_q <= s_d;
		end
	end

	assign prdata = s_q.prdata;
	assign pready = s_q.pready;
	assign pslverr = s_q.pslverr;
	// numerator over denominator scales the synth3 frequency
	assign synth3_numerator_field = ratio_w.live[`SCFG_NUMER_LSB +: `SCFG_FIELD_W];
	assign synth3_denominator_field = ratio_w.live[`SCFG_DENOM_LSB +: `SCFG_FIELD_W];
	// one shared offset for all synths, fout = finit * (1 + trim / 2^32)
	assign centre_trim = trim_w.live;
	assign synth_loop_select = s_q.synth_sel;
	assign synth_out_en = s_q.synth_en;
	assign loop0_lock_criterion = s_q.lock_crit[1:0];
	assign loop1_lock_criterion = s_q.lock_crit[3:2];
	assign loop_lock_fail = s_q.lock_fail;

	apb_one_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
		setup |=> pready ##1 !pready)
		else $error("apb answer not given in the first access cycle");

	apb_unmapped_a: assert property (@(posedge pclk) disable iff (!presetn)
		(setup && !hit) |=> pslverr && prdata == 32'h00000000)
		else $error("unmapped address not flagged");

	ratio_fields_a: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_en && idx == `SCFG_IDX_RATIO3 && pstrb == 4'hF) |=>
		(synth3_numerator_field == $past(wd_hi)) && (synth3_denominator_field == $past(wd_lo)))
		else $error("ratio fields not split into numerator and denominator");

	ratio_partial_a: assert property (@(posedge pclk) disable iff (!presetn)
		(ratio_w.wr && !u_ratio.full_now) |=> $stable(ratio_w.live))
		else $error("partial ratio write altered the live ratio");

	trim_full_a: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_en && idx == `SCFG_IDX_TRIM && pstrb == 4'hF) |=> centre_trim == $past(pwdata))
		else $error("trim word not applied");

	sel_follows_code_a: assert property (@(posedge pclk) disable iff (!presetn)
		(!s_q.loop_sel[1]) |=> synth_loop_select[0] == $past(s_q.loop_sel[0]))
		else $error("synth0 loop choice does not follow its field");

	sel_reserved_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		(s_q.loop_sel[7]) |=> $stable(synth_loop_select[3]))
		else $error("reserved code changed synth3 loop choice");

	enable_follows_a: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_en && idx == `SCFG_IDX_OUT_EN && pstrb[0]) |=> ##1 synth_out_en == $past(pwdata[3:0], 2))
		else $error("output enables do not follow the enable field");

	lock_status_a: assert property (@(posedge pclk) disable iff (!presetn)
		1'b1 |=> loop_lock_fail == ~$past(locked))
		else $error("lock fail status does not track the qualifier");

	crit_restart_a: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_en && idx == `SCFG_IDX_LOCK_CRIT && pstrb[0] && pwdata[1:0] != s_q.lock_crit[1:0])
		|=> ##2 loop_lock_fail[0])
		else $error("criterion change did not restart loop0 qualification");

	crit_restart_one_a: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_en && idx == `SCFG_IDX_LOCK_CRIT && pstrb[0] && pwdata[3:2] != s_q.lock_crit[3:2])
		|=> ##2 loop_lock_fail[1])
		else $error("criterion change did not restart loop1 qualification");

	crit_fields_a: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_en && idx == `SCFG_IDX_LOCK_CRIT && pstrb[0]) |=>
		(loop0_lock_criterion == $past(pwdata[1:0])) && (loop1_lock_criterion == $past(pwdata[3:2])))
		else $error("criterion fields not taken from their bit positions");

	// per-synth loop choice, one two-bit field each
	sel_follows_one_a: assert property (@(posedge pclk) disable iff (!presetn)
		(!s_q.loop_sel[3]) |=> synth_loop_select[1] == $past(s_q.loop_sel[2]))
		else $error("synth1 loop choice does not follow its field");

	sel_follows_two_a: assert property (@(posedge pclk) disable iff (!presetn)
		(!s_q.loop_sel[5]) |=> synth_loop_select[2] == $past(s_q.loop_sel[4]))
		else $error("synth2 loop choice does not follow its field");

	sel_follows_three_a: assert property (@(posedge pclk) disable iff (!presetn)
		(!s_q.loop_sel[7]) |=> synth_loop_select[3] == $past(s_q.loop_sel[6]))
		else $error("synth3 loop choice does not follow its field");

	sel_reserved_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
		(s_q.loop_sel[1]) |=> $stable(synth_loop_select[0]))
		else $error("reserved code changed synth0 loop choice");

	loop_sel_store_a: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_en && idx == `SCFG_IDX_LOOP_SEL && pstrb[0]) |=> s_q.loop_sel == $past(pwdata[7:0]))
		else $error("loop select write not stored");

	// output enables
	out_en_store_a: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_en && idx == `SCFG_IDX_OUT_EN && pstrb[0]) |=> s_q.out_en == $past(pwdata[7:0]))
		else $error("enable write not stored");

	enable_tracks_a: assert property (@(posedge pclk) disable iff (!presetn)
		1'b1 |=> synth_out_en == $past(s_q.out_en[3:0]))
		else $error("output enables do not track the stored field");

	// staged words stay put between complete writes
	ratio_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		(!ratio_w.wr) |=> $stable(ratio_w.live))
		else $error("live ratio changed without a write");

	trim_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		(!trim_w.wr) |=> $stable(centre_trim))
		else $error("live trim changed without a write");

	trim_partial_a: assert property (@(posedge pclk) disable iff (!presetn)
		(trim_w.wr && !u_trim.full_now) |=> $stable(centre_trim))
		else $error("partial trim write altered the live trim");

	// register bus
	apb_idle_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
		(!setup) |=> !pready)
		else $error("apb ready without a setup cycle");

	apb_write_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
		(setup && pwrite) |=> prdata == 32'h00000000)
		else $error("read data not zero on a write");

	unmapped_write_a: assert property (@(posedge pclk) disable iff (!presetn)
		(access && pwrite && !hit) |=> $stable(s_q.loop_sel) && $stable(s_q.out_en) && $stable(s_q.lock_crit))
		else $error("unmapped write altered a register");
endmodule : scfg_config_top

/* File: common/scfg_defines.svh */
// register indices, field positions, reset values and timing counts of the synth config block
`ifndef SCFG_DEFINES_SVH
`define SCFG_DEFINES_SVH

// register indices; byte address is four times the index
`define SCFG_IDX_RATIO3 8'h6C
`define SCFG_IDX_LOOP_SEL 8'h70
`define SCFG_IDX_OUT_EN 8'h71
`define SCFG_IDX_LOCK_CRIT 8'h72
`define SCFG_IDX_TRIM 8'h73
`define SCFG_IDX_LOCK_STAT 8'h77

// reset values
`define SCFG_RST_RATIO3 32'h00010001
`define SCFG_RST_LOOP_SEL 8'hE4
`define SCFG_RST_OUT_EN 8'h03
`define SCFG_RST_LOCK_CRIT 8'h00
`define SCFG_RST_TRIM 32'h046AAAAB

// field positions
`define SCFG_NUMER_LSB 16
`define SCFG_DENOM_LSB 0
`define SCFG_FIELD_W 16
`define SCFG_SEL_W 2
`define SCFG_CRIT_W 2
`define SCFG_NUM_SYNTH 4

// timing
`define SCFG_CLK_PERIOD_NS 10
`define SCFG_ERR_36_US 36
`define SCFG_ERR_10_US 10
`define SCFG_ERR_1_US 1
`define SCFG_DUR_SHORT_S 1
`define SCFG_DUR_LONG_S 10
`define SCFG_DUR_SHORT_CYC ((64'd`SCFG_DUR_SHORT_S * 64'd1000000000 + 64'd`SCFG_CLK_PERIOD_NS - 64'd1) / 64'd`SCFG_CLK_PERIOD_NS)
`define SCFG_DUR_LONG_CYC ((64'd`SCFG_DUR_LONG_S * 64'd1000000000 + 64'd`SCFG_CLK_PERIOD_NS - 64'd1) / 64'd`SCFG_CLK_PERIOD_NS)

`endif

/* File: common/scfg_pkg.sv */
// types shared by the synth config block
package scfg_pkg;
	typedef enum logic [2:0] {
		LK_UNLOCKED = 3'b001,
		LK_QUALIFY = 3'b010,
		LK_LOCKED = 3'b100
	} scfg_lock_st_t;

	typedef struct packed {
		logic [31:0] stage;
		logic [3:0] seen;
		logic [31:0] live;
	} scfg_shadow_t;

	typedef struct packed {
		scfg_lock_st_t st;
		logic [31:0] cnt;
		logic [1:0] crit;
	} scfg_lock_t;

	typedef struct packed {
		logic [7:0] loop_sel;
		logic [7:0] out_en;
		logic [7:0] lock_crit;
		logic [3:0] synth_sel;
		logic [3:0] synth_en;
		logic [1:0] lock_fail;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} scfg_top_t;
endpackage : scfg_pkg

/* File: common/scfg_word_if.sv */
// byte-lane write path and committed value of one multi-byte register
`timescale 1ns/1ns
interface scfg_word_if;
	logic wr;
	logic [3:0] strb;
	logic [31:0] wdata;
	logic [31:0] live;
	modport owner (output wr, output strb, output wdata, input live);
	modport store (input wr, input strb, input wdata, output live);
endinterface : scfg_word_if

/* File: core/scfg_shadow_word.sv */
// staging register that commits a 32-bit value only when all four bytes are written
`timescale 1ns/1ns
module scfg_shadow_word #(
	parameter logic [31:0] RESET_VAL = 32'h00000000
) (
	input logic pclk, // block clock
	input logic presetn, // async reset, active low
	scfg_word_if.store w // byte writes in, committed value out
);
	scfg_pkg::scfg_shadow_t s_q;
	scfg_pkg::scfg_shadow_t s_d;
	logic full_now;

	assign full_now = w.wr & (&(s_q.seen | w.strb));
	assign w.live = s_q.live;

	always_comb begin
		s_d = s_q;
		if (w.wr) begin
			for (int i = 0; i < 4; i++) begin
				if (w.strb[i]) begin
					s_d.stage[8*i +: 8] = w.wdata[8*i +: 8];
				end
			end
			s_d.seen = s_q.seen | w.strb;
			if (full_now) begin
				s_d.live = s_d.stage;
				s_d.seen = 4'h0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '{stage: RESET_VAL, seen: 4'h0, live: RESET_VAL};
		end else begin
			s_q <= s_d;
		end
	end

	commit_when_whole_a: assert property (@(posedge pclk) disable iff (!presetn)
		$changed(s_q.live) |-> $past(full_now))
		else $error("committed value changed without a complete word");

	commit_takes_stage_a: assert property (@(posedge pclk) disable iff (!presetn)
		(w.wr && w.strb == 4'hF) |=> (s_q.live == $past(w.wdata)) && (s_q.seen == 4'h0))
		else $error("full word write not committed");
endmodule : scfg_shadow_word

/* File: core/scfg_lock_timer.sv */
// qualifies one loop's lock: phase error below a threshold for a chosen duration
`timescale 1ns/1ns
`include "scfg_defines.svh"
module scfg_lock_timer #(
	parameter int ERR_W = 16,
	parameter logic [31:0] SHORT_CYC = 32'(`SCFG_DUR_SHORT_CYC),
	parameter logic [31:0] LONG_CYC = 32'(`SCFG_DUR_LONG_CYC)
) (
	input logic pclk, // block clock
	input logic presetn, // async reset, active low
	input logic [1:0] crit, // lock criterion code
	input logic [ERR_W-1:0] phase_err_ns, // phase error magnitude in ns
	output logic locked // criterion met
);
	scfg_pkg::scfg_lock_t s_q;
	scfg_pkg::scfg_lock_t s_d;
	logic [ERR_W-1:0] thr;
	logic [31:0] dur;
	logic below;

	always_comb begin
		case (crit)
			2'b00: begin
				thr = ERR_W'(`SCFG_ERR_36_US * 1000);
				dur = LONG_CYC;
			end
			2'b01: begin
				thr = ERR_W'(`SCFG_ERR_1_US * 1000);
				dur = SHORT_CYC;
			end
			2'b10: begin
				thr = ERR_W'(`SCFG_ERR_10_US * 1000);
				dur = SHORT_CYC;
			end
			default: begin
				thr = ERR_W'(`SCFG_ERR_10_US * 1000);
				dur = LONG_CYC;
			end
		endcase
	end

	assign below = phase_err_ns < thr;
	assign locked = s_q.st == scfg_pkg::LK_LOCKED;

	always_comb begin
		s_d = s_q;
		s_d.crit = crit;
		case (s_q.st)
			scfg_pkg::LK_UNLOCKED: begin
				if (below) begin
					s_d.st = scfg_pkg::LK_QUALIFY;
					s_d.cnt = 32'd1;
				end
			end
			scfg_pkg::LK_QUALIFY: begin
				if (!below) begin
					s_d.st = scfg_pkg::LK_UNLOCKED;
					s_d.cnt = 32'd0;
				end else if (s_q.cnt >= dur) begin
					s_d.st = scfg_pkg::LK_LOCKED;
				end else begin
					s_d.cnt = s_q.cnt + 32'd1;
				end
			end
			scfg_pkg::LK_LOCKED: begin
				if (!below) begin
					s_d.st = scfg_pkg::LK_UNLOCKED;
					s_d.cnt = 32'd0;
				end
			end
			default: begin
				s_d.st = scfg_pkg::LK_UNLOCKED;
				s_d.cnt = 32'd0;
			end
		endcase
		// a new criterion restarts qualification
		if (crit != s_q.crit) begin
			s_d.st = scfg_pkg::LK_UNLOCKED;
			s_d.cnt = 32'd0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '{st: scfg_pkg::LK_UNLOCKED, cnt: 32'd0, crit: 2'b00};
		end else begin
			s_q <= s_d;
		end
	end

	lock_drops_fast_a: assert property (@(posedge pclk) disable iff (!presetn)
		(locked && !below) |=> !locked)
		else $error("lock held with phase error above threshold");

	lock_needs_time_a: assert property (@(posedge pclk) disable iff (!presetn)
		(!locked ##1 locked) |-> ($past(s_q.cnt) >= $past(dur)))
		else $error("lock declared before the qualifying duration");
endmodule : scfg_lock_timer

/* File: testbench/scfg_config_top_bench.sv */
// self-checking bench for the synth config register block
`timescale 1ns/1ns
`include "scfg_defines.svh"
module scfg_config_top_bench;
	localparam logic [31:0] SH = 32'h00000014;
	localparam logic [31:0] LG = 32'h00000032;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, trim, rd;
	logic [3:0] pstrb, sel_o, en_o;
	logic [15:0] err0, err1, numer, denom;
	logic [1:0] crit0, crit1, fail;
	int error_cnt, n_tests, thr, dur;

	scfg_config_top #(.ADDR_W(12), .ERR_W(16), .LOCK_SHORT_CYC(SH), .LOCK_LONG_CYC(LG)) dut_u (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .loop0_phase_err_ns(err0), .loop1_phase_err_ns(err1),
		.synth3_numerator_field(numer), .synth3_denominator_field(denom), .centre_trim(trim),
		.synth_loop_select(sel_o), .synth_out_en(en_o), .loop0_lock_criterion(crit0),
		.loop1_lock_criterion(crit1), .loop_lock_fail(fail));

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	task results;
		$display("checks %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : results

	task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	// one transfer; entered just after a rising edge, returns one idle edge after release
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 20) begin
			@(posedge pclk);
			n++;
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
		if (pready !== 1'b1 && n >= 20) begin
			$display("mismatch pready expected 1 seen timeout");
			error_cnt++;
			results;
		end
	endtask : apb

	function automatic logic [11:0] ad(input logic [7:0] idx);
		return {2'b00, idx, 2'b00};
	endfunction : ad

	task wr(input logic [7:0] idx, input logic [31:0] d, input logic [3:0] s);
		apb(1'b1, ad(idx), d, s);
		chk("write error flag", 32'h0, {31'h0, er});
	endtask : wr

	task rdc(input logic [7:0] idx, input string name, input logic [31:0] exp, input logic eerr);
		apb(1'b0, ad(idx), 32'h0, 4'h0);
		chk(name, exp, rd);
		chk("read error flag", {31'h0, eerr}, {31'h0, er});
	endtask : rdc

	// lets a committed write reach the outputs, then samples mid-cycle
	task settle;
		@(posedge pclk);
		@(negedge pclk);
	endtask : settle

	initial begin
		#500000;
		$display("mismatch run length expected finish seen timeout");
		error_cnt++;
		results;
	end

	initial begin
		error_cnt = 0;
		n_tests = 0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		pstrb = 4'h0;
		err0 = 16'hFFFF;
		err1 = 16'hFFFF;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		settle;
		chk("select out", 32'h2, {28'h0, sel_o});
		chk("enable out", 32'h3, {28'h0, en_o});
		chk("numerator", 32'h1, {16'h0, numer});
		chk("denominator", 32'h1, {16'h0, denom});
		chk("trim out", `SCFG_RST_TRIM, trim);
		chk("lock fail", 32'h3, {30'h0, fail});
		@(posedge pclk);
		rdc(`SCFG_IDX_RATIO3, "ratio", `SCFG_RST_RATIO3, 1'b0);
		rdc(`SCFG_IDX_LOOP_SEL, "loop select", 32'hE4, 1'b0);
		rdc(`SCFG_IDX_OUT_EN, "enables", 32'h03, 1'b0);
		rdc(`SCFG_IDX_LOCK_CRIT, "criterion", 32'h00, 1'b0);
		rdc(`SCFG_IDX_TRIM, "trim", 32'h046AAAAB, 1'b0);
		rdc(`SCFG_IDX_LOCK_STAT, "lock status", 32'h3, 1'b0);
		rdc(8'h74, "unmapped read", 32'h0, 1'b1);
		apb(1'b1, ad(8'h74), 32'hFFFFFFFF, 4'hF);
		chk("unmapped write flag", 32'h1, {31'h0, er});
		wr(`SCFG_IDX_LOCK_STAT, 32'h0, 4'hF);
		rdc(`SCFG_IDX_LOCK_STAT, "status after write", 32'h3, 1'b0);
		wr(`SCFG_IDX_OUT_EN, 32'hAC, 4'h1);
		settle;
		chk("enable out", 32'hC, {28'h0, en_o});
		@(posedge pclk);
		wr(`SCFG_IDX_OUT_EN, 32'h53, 4'h2);
		rdc(`SCFG_IDX_OUT_EN, "enables", 32'hAC, 1'b0);
		wr(`SCFG_IDX_LOOP_SEL, 32'h44, 4'h1);
		settle;
		chk("select out", 32'hA, {28'h0, sel_o});
		@(posedge pclk);
		wr(`SCFG_IDX_LOOP_SEL, 32'hEE, 4'h1);
		settle;
		chk("select reserved", 32'hA, {28'h0, sel_o});
		@(posedge pclk);
		rdc(`SCFG_IDX_LOOP_SEL, "loop select", 32'hEE, 1'b0);
		wr(`SCFG_IDX_LOOP_SEL, 32'h11, 4'h1);
		settle;
		chk("select out", 32'h5, {28'h0, sel_o});
		@(posedge pclk);
		wr(`SCFG_IDX_RATIO3, 32'h123400ED, 4'h3);
		settle;
		chk("numerator half", 32'h1, {16'h0, numer});
		chk("denominator half", 32'h1, {16'h0, denom});
		@(posedge pclk);
		rdc(`SCFG_IDX_RATIO3, "ratio half", 32'h00010001, 1'b0);
		wr(`SCFG_IDX_RATIO3, 32'h00FF5678, 4'hC);
		settle;
		chk("numerator", 32'hFF, {16'h0, numer});
		chk("denominator", 32'hED, {16'h0, denom});
		@(posedge pclk);
		rdc(`SCFG_IDX_RATIO3, "ratio", 32'h00FF00ED, 1'b0);
		wr(`SCFG_IDX_TRIM, 32'h0539782A, 4'hF);
		settle;
		chk("trim slow osc", 32'h0539782A, trim);
		@(posedge pclk);
		wr(`SCFG_IDX_TRIM, 32'hFAFAFAFB, 4'hF);
		wr(`SCFG_IDX_TRIM, 32'h0, 4'h1);
		wr(`SCFG_IDX_TRIM, 32'h0, 4'h6);
		settle;
		chk("trim partial", 32'hFAFAFAFB, trim);
		@(posedge pclk);
		wr(`SCFG_IDX_TRIM, 32'h0, 4'h8);
		settle;
		chk("trim", 32'h0, trim);
		@(posedge pclk);
		for (int c = 0; c < 4; c++) begin
			thr = (c == 0) ? 36000 : ((c == 1) ? 1000 : 10000);
			dur = (c == 1 || c == 2) ? int'(SH) : int'(LG);
			err0 <= 16'(thr);
			err1 <= 16'(thr);
			wr(`SCFG_IDX_LOCK_CRIT, 32'(c * 5), 4'h1);
			settle;
			chk("criterion 0", 32'(c), {30'h0, crit0});
			chk("criterion 1", 32'(c), {30'h0, crit1});
			@(posedge pclk);
			err0 <= 16'(thr - 1);
			err1 <= 16'(thr - 1);
			// lock comes dur edges after the first low sample, status one edge later
			repeat (dur + 1) @(posedge pclk);
			@(negedge pclk);
			chk("lock early", 32'h3, {30'h0, fail});
			@(negedge pclk);
			chk("lock reached", 32'h0, {30'h0, fail});
			@(posedge pclk);
			rdc(`SCFG_IDX_LOCK_STAT, "lock status", 32'h0, 1'b0);
			err0 <= 16'(thr);
			repeat (3) @(posedge pclk);
			@(negedge pclk);
			chk("lock lost", 32'h1, {30'h0, fail});
			@(posedge pclk);
		end
		results;
	end
endmodule : scfg_config_top_bench
